//--- design/port0_direction_function_mux.sv
// Port 0 register file, direction and alternate function multiplexing.
`timescale 1ns/100ps
`default_nettype none
`include "port0_defs.svh"
module port0_direction_function_mux (
  input  wire logic       i_clk_sys,
  input  wire logic       i_arst_n,
  input  wire logic [7:0] i_sfr_addr,
  input  wire logic [7:0] i_sfr_wdata,
  input  wire logic       i_sfr_write,
  input  wire logic       i_sfr_read,
  output logic      [7:0] o_sfr_rdata,
  input  wire logic [7:0] i_pad,
  output logic      [7:0] o_pad,
  output logic      [7:0] o_pad_oe_n,
  input  wire logic       i_uart_tx,
  input  wire logic       i_uart_rx_out,
  input  wire logic       i_pwm_out,
  output logic            o_uart_rx,
  output logic            o_ext_interrupt_a_n,
  output logic            o_ext_interrupt_b_n,
  output logic            o_timer0_count_input,
  output logic            o_timer1_count_input
);
  port0_pkg::port0_state_s state_reg;
  port0_pkg::port0_state_s state_next;
  logic [7:0]              alt_sel;
  logic [7:0]              alt_out_en;
  logic [7:0]              drive_en;
  logic [7:0]              drive_val;

  // Next-state: register writes and read capture.
  always_comb begin
    state_next = state_reg;
    if (i_sfr_write) begin
      unique case (i_sfr_addr)
        `PORT0_DATA_ADDR:            state_next.data = i_sfr_wdata;
        `PORT0_DIRECTION_ADDR:       state_next.direction = i_sfr_wdata;
        `PORT0_FUNCTION_SELECT_ADDR: state_next.function_select = i_sfr_wdata;
        default:                     state_next.data = state_reg.data;
      endcase
    end
    // Reads return pad levels for data, stored values otherwise; others read zero.
    if (i_sfr_read) begin
      unique case (i_sfr_addr)
        `PORT0_DATA_ADDR:            state_next.read_data = i_pad;
        `PORT0_DIRECTION_ADDR:       state_next.read_data = state_reg.direction;
        `PORT0_FUNCTION_SELECT_ADDR: state_next.read_data = state_reg.function_select;
        default:                     state_next.read_data = 8'h00;
      endcase
    end
  end

  // Direction and function select writes land on the following edge.
  dir_write_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    i_sfr_write && i_sfr_addr == `PORT0_DIRECTION_ADDR
      |=> state_reg.direction == $past(i_sfr_wdata))
    else $error("direction write lost");
  func_write_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    i_sfr_write && i_sfr_addr == `PORT0_FUNCTION_SELECT_ADDR
      |=> state_reg.function_select == $past(i_sfr_wdata))
    else $error("function select write lost");

  // A write to any other address must leave all three registers untouched.
  stray_write_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    i_sfr_write && i_sfr_addr != `PORT0_DATA_ADDR
      && i_sfr_addr != `PORT0_DIRECTION_ADDR
      && i_sfr_addr != `PORT0_FUNCTION_SELECT_ADDR
      |=> $stable(state_reg.data) && $stable(state_reg.direction)
      && $stable(state_reg.function_select))
    else $error("unmapped write changed a register");

  // Control registers read back as stored; other addresses read zero.
  dir_read_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    i_sfr_read && i_sfr_addr == `PORT0_DIRECTION_ADDR
      |=> o_sfr_rdata == $past(state_reg.direction))
    else $error("direction read wrong");
  func_read_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    i_sfr_read && i_sfr_addr == `PORT0_FUNCTION_SELECT_ADDR
      |=> o_sfr_rdata == $past(state_reg.function_select))
    else $error("function select read wrong");
  stray_read_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    i_sfr_read && i_sfr_addr != `PORT0_DATA_ADDR
      && i_sfr_addr != `PORT0_DIRECTION_ADDR
      && i_sfr_addr != `PORT0_FUNCTION_SELECT_ADDR
      |=> o_sfr_rdata == 8'h00)
    else $error("unmapped read not zero");

  // Read data holds between reads, so a slow master still finds it.
  rdata_hold_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    !i_sfr_read |=> $stable(o_sfr_rdata))
    else $error("read data changed without a read");

  // State register; resets leave every pin an input.
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_reg.data            <= `PORT0_DATA_RESET;
      state_reg.direction       <= `PORT0_DIRECTION_RESET;
      state_reg.function_select <= `PORT0_FUNCTION_RESET;
      state_reg.read_data       <= 8'h00;
    end else begin
      state_reg <= state_next;
    end
  end

  // Reset values stand at the first edge after release, before any write lands.
  reset_values_a: assert property (@(posedge i_clk_sys)
    $rose(i_arst_n) |-> state_reg.data == `PORT0_DATA_RESET
      && state_reg.direction == `PORT0_DIRECTION_RESET
      && state_reg.function_select == `PORT0_FUNCTION_RESET)
    else $error("register reset value wrong");

  // While reset is low every pad stays an input.
  reset_hold_a: assert property (@(posedge i_clk_sys)
    !i_arst_n |-> o_pad_oe_n == 8'hff)
    else $error("pad driven during reset");

  // Bit 0 never takes an alternate function.
  assign alt_sel = {state_reg.function_select[7:1], 1'b0};

  // The boot select pad always shows the data latch, whatever its select bit.
  bit0_data_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    o_pad[`BIT_BOOT_SELECT] == state_reg.data[`BIT_BOOT_SELECT])
    else $error("bit 0 not from data latch");

  // Alternate direction: transmit and PWM drive, receive follows direction.
  always_comb begin
    alt_out_en = `ALT_OUTPUT_MASK;
    alt_out_en[`BIT_UART_RX] = ~state_reg.direction[`BIT_UART_RX];
  end

  // A selected receive pin set to output carries the receiver-side value.
  rx_drive_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    state_reg.function_select[`BIT_UART_RX] && !state_reg.direction[`BIT_UART_RX]
      |-> !o_pad_oe_n[`BIT_UART_RX] && o_pad[`BIT_UART_RX] == i_uart_rx_out)
    else $error("receive pin not driven");
  tx_drive_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    state_reg.function_select[`BIT_UART_TX]
      |-> !o_pad_oe_n[`BIT_UART_TX] && o_pad[`BIT_UART_TX] == i_uart_tx)
    else $error("transmit pin not driven");

  // Selected interrupt and counter pins are inputs whatever the direction says.
  alt_inputs_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    (o_pad_oe_n & state_reg.function_select & `ALT_INPUT_MASK)
      == (state_reg.function_select & `ALT_INPUT_MASK))
    else $error("alternate input pin driven");

  // Per-bit priority: function select first, then direction.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      drive_en[i] = alt_sel[i] ? alt_out_en[i] : ~state_reg.direction[i];
    end
    drive_val = state_reg.data;
    if (alt_sel[`BIT_UART_RX])
      drive_val[`BIT_UART_RX] = i_uart_rx_out;
    if (alt_sel[`BIT_UART_TX])
      drive_val[`BIT_UART_TX] = i_uart_tx;
    if (alt_sel[`BIT_PWM])
      drive_val[`BIT_PWM] = i_pwm_out;
  end

  // Without a select every pad follows its direction bit and its data latch.
  gpio_all_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    ((o_pad_oe_n ^ state_reg.direction) & ~alt_sel) == 8'h00)
    else $error("gpio enable wrong");
  gpio_value_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    ((o_pad ^ state_reg.data) & ~(alt_sel & `ALT_DRIVEN_MASK)) == 8'h00)
    else $error("gpio value wrong");

  // Async reset forces inputs with or without a clock.
  assign o_pad_oe_n  = i_arst_n ? ~drive_en : 8'hff;
  assign o_pad       = drive_val;
  assign o_sfr_rdata = state_reg.read_data;

  // Inputs to peripherals; interrupts idle high unless selected.
  assign o_uart_rx            = i_pad[`BIT_UART_RX];
  assign o_ext_interrupt_a_n  = alt_sel[`BIT_EXT_INT_A] ? i_pad[`BIT_EXT_INT_A] : 1'b1;
  assign o_ext_interrupt_b_n  = alt_sel[`BIT_EXT_INT_B] ? i_pad[`BIT_EXT_INT_B] : 1'b1;
  assign o_timer0_count_input = alt_sel[`BIT_TIMER0] & i_pad[`BIT_TIMER0];
  assign o_timer1_count_input = alt_sel[`BIT_TIMER1] & i_pad[`BIT_TIMER1];

  // Selected interrupt pins pass the pad level; the second one idles high.
  int_a_pass_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    state_reg.function_select[`BIT_EXT_INT_A] |-> o_ext_interrupt_a_n == i_pad[`BIT_EXT_INT_A])
    else $error("interrupt a not passed");
  int_b_gate_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    !state_reg.function_select[`BIT_EXT_INT_B] |-> o_ext_interrupt_b_n)
    else $error("interrupt b passed unselected");
  int_b_pass_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    state_reg.function_select[`BIT_EXT_INT_B] |-> o_ext_interrupt_b_n == i_pad[`BIT_EXT_INT_B])
    else $error("interrupt b not passed");

  // Counter inputs see the pad only when selected; the receiver always sees bit 1.
  timer0_path_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    o_timer0_count_input == (state_reg.function_select[`BIT_TIMER0] && i_pad[`BIT_TIMER0]))
    else $error("timer 0 input wrong");
  timer1_path_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    o_timer1_count_input == (state_reg.function_select[`BIT_TIMER1] && i_pad[`BIT_TIMER1]))
    else $error("timer 1 input wrong");
  rx_input_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    o_uart_rx == i_pad[`BIT_UART_RX])
    else $error("receive input wrong");

  // Direction reset, function select mapping, data latch load and pad read.
  reset_inputs_a: assert property (@(posedge i_clk_sys)
    $rose(i_arst_n) |-> $past(o_pad_oe_n) == 8'hff)
    else $error("pins not inputs during reset");
  bit0_gpio_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    o_pad_oe_n[0] == state_reg.direction[0])
    else $error("bit 0 not under direction");
  priority_sel_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    state_reg.function_select[7] |-> !o_pad_oe_n[7] && o_pad[7] == i_pwm_out)
    else $error("pwm not driving");
  rx_dir_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    o_pad_oe_n[1] == state_reg.direction[1])
    else $error("receive pin direction wrong");
  gpio_dir_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    !state_reg.function_select[5] |-> o_pad_oe_n[5] == state_reg.direction[5])
    else $error("gpio direction wrong");
  int_gate_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    !state_reg.function_select[3] |-> o_ext_interrupt_a_n)
    else $error("interrupt passed unselected");
  data_write_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    i_sfr_write && i_sfr_addr == `PORT0_DATA_ADDR
      |=> ((o_pad ^ $past(i_sfr_wdata)) & ~(alt_sel & `ALT_DRIVEN_MASK)) == 8'h00)
    else $error("data latch not loaded");
  read_pad_a: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n)
    i_sfr_read && i_sfr_addr == `PORT0_DATA_ADDR |=> o_sfr_rdata == $past(i_pad))
    else $error("pad read wrong");
endmodule : port0_direction_function_mux
`default_nettype wire

//--- design/port0_defs.svh
// Constants for the eight-pin general-purpose port with alternate functions.
// Contract
// - All pins are inputs during internal reset.
// - Function select outranks the direction bit.
// - Alternate direction rules, except receive follows direction.
// - Bits map receive, transmit, interrupts, counters, PWM.
// - Without function select, direction 0 out, 1 in.
// - Interrupt inputs pass only when selected.
// - Bit 0 is always general-purpose input/output.
// - Registers sit at 0x80, 0x94 and 0x95.
// - Data bits drive pads 0-7; resets ff, ff, 00.
`ifndef PORT0_DEFS_SVH
`define PORT0_DEFS_SVH
`define PORT0_DATA_ADDR            8'h80
`define PORT0_DIRECTION_ADDR       8'h94
`define PORT0_FUNCTION_SELECT_ADDR 8'h95
`define PORT0_DATA_RESET           8'hff
`define PORT0_DIRECTION_RESET      8'hff
`define PORT0_FUNCTION_RESET       8'h00
`define BIT_BOOT_SELECT            0
`define BIT_UART_RX                1
`define BIT_UART_TX                2
`define BIT_EXT_INT_A              3
`define BIT_EXT_INT_B              4
`define BIT_TIMER0                 5
`define BIT_TIMER1                 6
`define BIT_PWM                    7
// Alternate-function pins that always drive out: transmit and PWM.
`define ALT_OUTPUT_MASK            8'h84
// Alternate-function pins that always listen: interrupts and counters.
`define ALT_INPUT_MASK             8'h78
// Pads whose value an alternate function replaces: receive, transmit, PWM.
`define ALT_DRIVEN_MASK            8'h86
`endif

//--- design/port0_pkg.sv
// Types shared by the port logic.
package port0_pkg;
  typedef logic [7:0] byte_t;
  typedef struct packed {
    byte_t data;
    byte_t direction;
    byte_t function_select;
    byte_t read_data;
  } port0_state_s;
endpackage : port0_pkg

//--- tb/pad_world.sv
// Model of the outside world that meets the port's pads.
`timescale 1ns/100ps
`default_nettype none
module pad_world (
  input  wire logic [7:0] i_pad_out,
  input  wire logic [7:0] i_pad_oe_n,
  input  wire logic [7:0] i_ext_drive,
  output logic      [7:0] o_pad_level
);
  // A pad shows the port's value while driven, else the outside source; bit 0 is boot select.
  assign o_pad_level = (i_pad_oe_n & i_ext_drive) | (~i_pad_oe_n & i_pad_out);
endmodule : pad_world
`default_nettype wire

//--- tb/tb_port0_direction_function_mux.sv
// Self-checking bench for the port 0 direction and function multiplexer.
`timescale 1ns/100ps
`default_nettype none
`include "port0_defs.svh"
module tb_port0_direction_function_mux;
  logic       clk, rst_n, we, re, tx, rxo, pwm, rx, ia_n, ib_n, t0, t1;
  logic [7:0] adr, wd, rdata, pad, po, oe_n, ext, d, r, f, eo, ep;
  int         errors = 0;
  int         samples_checked = 0;
  // Expected enables: select outranks direction; bits 0 and 1 follow direction.
  function automatic logic [7:0] exp_oe(logic [7:0] dr, logic [7:0] fs);
    exp_oe = (dr & ~(fs & 8'hfc)) | (fs & 8'h78);
  endfunction : exp_oe
  function automatic logic [7:0] exp_out(logic [7:0] da, logic [7:0] fs);
    exp_out = {fs[7] ? pwm : da[7], da[6:3], fs[2] ? tx : da[2], fs[1] ? rxo : da[1], da[0]};
  endfunction : exp_out
  task automatic chk(logic [7:0] g, logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // Each bus task starts on its own edge, so strobes never change twice in one step.
  task automatic wr(logic [7:0] a, logic [7:0] v);
    @(posedge clk);
    adr <= a;
    wd <= v;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask : wr
  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(posedge clk);
    adr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    @(negedge clk);
    chk(rdata, e);
  endtask : rd
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test
  port0_direction_function_mux dut (.i_clk_sys(clk), .i_arst_n(rst_n), .i_sfr_addr(adr),
    .i_sfr_wdata(wd), .i_sfr_write(we), .i_sfr_read(re), .o_sfr_rdata(rdata), .i_pad(pad),
    .o_pad(po), .o_pad_oe_n(oe_n), .i_uart_tx(tx), .i_uart_rx_out(rxo), .i_pwm_out(pwm),
    .o_uart_rx(rx), .o_ext_interrupt_a_n(ia_n), .o_ext_interrupt_b_n(ib_n),
    .o_timer0_count_input(t0), .o_timer1_count_input(t1));
  pad_world world (.i_pad_out(po), .i_pad_oe_n(oe_n), .i_ext_drive(ext), .o_pad_level(pad));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Cuts a hang short.
  initial begin
    #1000000;
    errors++;
    stop_test();
  end
  initial begin
    {rst_n, we, re, tx, rxo, pwm, adr, wd} = '0;
    ext = 8'h5a;
    void'($urandom(32'h1b89));
    repeat (10) @(negedge clk);
    chk(oe_n & po, 8'hff);
    @(posedge clk);
    rst_n <= 1'b1;
    rd(`PORT0_FUNCTION_SELECT_ADDR, 8'h00);
    rd(8'h81, 8'h00);
    rd(`PORT0_DATA_ADDR, ext);
    wr(8'h81, 8'h5a);
    wr(`PORT0_DIRECTION_ADDR, 8'h00);
    @(negedge clk);
    chk(po, 8'hff);
    rd(`PORT0_FUNCTION_SELECT_ADDR, 8'h00);
    for (int i = 0; i < 40; i++) begin
      @(posedge clk);
      ext <= 8'($urandom());
      {tx, rxo, pwm} <= 3'($urandom());
      d = 8'($urandom());
      r = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom());
      f = (i < 2) ? 8'hff : 8'($urandom());
      wr(`PORT0_DATA_ADDR, d);
      wr(`PORT0_DIRECTION_ADDR, r);
      wr(`PORT0_FUNCTION_SELECT_ADDR, f);
      @(negedge clk);
      eo = exp_oe(r, f);
      ep = (eo & ext) | (~eo & exp_out(d, f));
      chk(oe_n, eo);
      chk(po & ~eo, exp_out(d, f) & ~eo);
      chk({3'h0, t1, t0, ib_n, ia_n, rx}, {3'h0, f[6] & ext[6], f[5] & ext[5],
        ~f[4] | ext[4], ~f[3] | ext[3], ep[1]});
      rd(`PORT0_DATA_ADDR, ep);
      rd(`PORT0_DIRECTION_ADDR, r);
      rd(`PORT0_FUNCTION_SELECT_ADDR, f);
      $display("test %0d done", i);
    end
    @(posedge clk);
    rst_n <= 1'b0;
    @(negedge clk);
    chk(oe_n & po, 8'hff);
    @(posedge clk);
    rst_n <= 1'b1;
    rd(`PORT0_DIRECTION_ADDR, 8'hff);
    stop_test();
  end
endmodule : tb_port0_direction_function_mux
`default_nettype wire
